// File: pkg/config_fuse_cfg.svh
// Configuration fuse locations, field positions, codes and counts
`ifndef CONFIG_FUSE_CFG_SVH
`define CONFIG_FUSE_CFG_SVH

// ----------------------------------------------------------------------
// Configuration word locations
// ----------------------------------------------------------------------
`define OFS_BOOT_SEGMENT_PROTECT_CFG    24'hf80000
`define OFS_GENERAL_SEGMENT_PROTECT_CFG 24'hf80004
`define OFS_OSCILLATOR_SELECT_CFG       24'hf80006
`define OFS_OSCILLATOR_CFG              24'hf80008
`define OFS_WATCHDOG_CFG                24'hf8000a
`define OFS_RESET_CFG                   24'hf8000c
`define OFS_DEBUGGER_CFG                24'hf8000e
`define CFG_SPACE_BASE                  24'h800000

// ----------------------------------------------------------------------
// Captured word indices
// ----------------------------------------------------------------------
`define CFG_WORD_COUNT  3'h7
`define IDX_BOOT        3'h0
`define IDX_GENERAL     3'h1
`define IDX_OSC_SELECT  3'h2
`define IDX_OSC         3'h3
`define IDX_WATCHDOG    3'h4
`define IDX_RESET       3'h5
`define IDX_DEBUGGER    3'h6
`define CFG_LAST_IDX    3'h6
`define CFG_UNPROGRAMMED 8'hff

// ----------------------------------------------------------------------
// Segment layout
// ----------------------------------------------------------------------
`define BOOT_ENTRY_LO    24'h000200
`define BOOT_ENTRY_HI    24'h00023f
`define BOOT_END_DEFAULT 24'h0007ff

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BSS_HI        3
`define BSS_LO        1
`define BOOT_WRITE_PROTECT_BIT      0
`define GSS_BIT       1
`define GENERAL_WRITE_PROTECT_BIT      0
`define POSC_HI       1
`define POSC_LO       0
`define CLKOUT_BIT    2
`define CSM_HI        7
`define CSM_LO        6
`define RSTPIN_BIT    7
`define BROWNOUT_TRIP_SEL_HI       6
`define BROWNOUT_TRIP_SEL_LO       5
`define POWERUP_TIMER_EN_BIT    3
`define BROWNOUT_EN_SEL_HI      1
`define BROWNOUT_EN_SEL_LO      0

// ----------------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------------
`define BSS_NONE      3'h7
`define BSS_STD_A     3'h6
`define BSS_STD_B     3'h5
`define POSC_XT       2'h1
`define POSC_EC       2'h0

// ----------------------------------------------------------------------
// Serial programming frame
// ----------------------------------------------------------------------
`define SP_HDR_BITS     5'h19
`define SP_BYTE_BITS    5'h08
`define SP_REFUSED_DATA 8'h00

`endif

// File: pkg/config_fuse_pkg.sv
// Types shared by the configuration fuse and protection logic
package config_fuse_pkg;
  `include "config_fuse_cfg.svh"

  typedef enum logic [2:0] {
    LD_ISSUE = 3'h1,
    LD_WAIT  = 3'h2,
    LD_RUN   = 3'h4
  } load_st_t;

  typedef enum logic [3:0] {
    SP_HEADER = 4'h1,
    SP_WDATA  = 4'h2,
    SP_RWAIT  = 4'h4,
    SP_RDATA  = 4'h8
  } ser_st_t;

  typedef enum logic [2:0] {
    OWN_LOAD = 3'h1,
    OWN_TBL  = 3'h2,
    OWN_SER  = 3'h4
  } mem_owner_t;

  typedef struct packed {
    ser_st_t     st;
    logic [2:0]  clkSync;
    logic [2:0]  datSync;
    logic        clkLvl;
    logic        datLvl;
    logic [24:0] shift;
    logic [4:0]  cnt;
    logic        dataOut;
    logic        dataOe_n;
    logic        cmdValid;
    logic        cmdWrite;
    logic [23:0] cmdAddr;
    logic [7:0]  cmdWdata;
  } ser_state_t;

  typedef struct packed {
    load_st_t                           ld;
    logic [2:0]                         idx;
    logic [`CFG_WORD_COUNT-3'h1:0][7:0] cfg;
    logic                               cfgLoaded;
    logic                               memReq;
    logic                               memWrite;
    logic [23:0]                        memAddr;
    logic [7:0]                         memWdata;
    mem_owner_t                         owner;
    logic                               rdPend;
    mem_owner_t                         rdOwner;
    logic                               tblAck;
    logic                               tblDeny;
    logic [7:0]                         tblRdata;
    logic                               fetchFault;
    logic                               illegalOpReset;
    logic                               spPend;
    logic                               spWrite;
    logic [23:0]                        spAddr;
    logic [7:0]                         spWdata;
    logic                               rspValid;
    logic [7:0]                         rspData;
    logic                               bootSegmentEn;
    logic                               bootHighSecurity;
    logic [1:0]                         primaryOscModeSel;
    logic                               crystalMode;
    logic                               extClockMode;
    logic                               powerupTimerEn;
    logic [1:0]                         clockSwitchMonitorSel;
    logic                               clockOutPinSel;
    logic                               resetPinEn;
    logic [1:0]                         brownoutTripSel;
    logic [1:0]                         brownoutEnSel;
  } prot_state_t;
endpackage : config_fuse_pkg

// File: pkg/serial_cmd_if.sv
// Command and answer path between the serial programming port and the core
`timescale 1ns/1ps
interface serial_cmd_if;
  logic        cmdValid;
  logic        cmdWrite;
  logic [23:0] cmdAddr;
  logic [7:0]  cmdWdata;
  logic        rspValid;
  logic [7:0]  rspData;

  modport port (output cmdValid, cmdWrite, cmdAddr, cmdWdata, input rspValid, rspData);
  modport core (input cmdValid, cmdWrite, cmdAddr, cmdWdata, output rspValid, rspData);
endinterface : serial_cmd_if

// File: logic/serial_prog_port.sv
// Two-wire serial programming port: pin sampling and frame shifting
`timescale 1ns/1ps
module serial_prog_port
  import config_fuse_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst_n,
  input  wire logic   programClockPin,
  input  wire logic   programDataPinIn,
  output logic        programDataPinOut,
  output logic        programDataPinOe_n,
  serial_cmd_if.port  cmd
);
  ser_state_t serState_ff;
  ser_state_t nxt_serState;
  logic       clkRise;

  // ----------------------------------------------------------------------
  // Frame sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_serState = serState_ff;
    nxt_serState.clkSync = {serState_ff.clkSync[1:0], programClockPin};
    nxt_serState.datSync = {serState_ff.datSync[1:0], programDataPinIn};
    nxt_serState.cmdValid = 1'b0;
    clkRise = (serState_ff.clkSync[1] == serState_ff.clkSync[2]) &&
              serState_ff.clkSync[2] && !serState_ff.clkLvl;
    if (serState_ff.clkSync[1] == serState_ff.clkSync[2]) begin
      nxt_serState.clkLvl = serState_ff.clkSync[2];
    end
    if (serState_ff.datSync[1] == serState_ff.datSync[2]) begin
      nxt_serState.datLvl = serState_ff.datSync[2];
    end
    unique case (serState_ff.st)
      SP_HEADER: begin
        if (clkRise) begin
          nxt_serState.shift = {serState_ff.shift[23:0], serState_ff.datLvl};
          nxt_serState.cnt = serState_ff.cnt + 5'h01;
          if (serState_ff.cnt == `SP_HDR_BITS - 5'h01) begin
            nxt_serState.cnt = 5'h00;
            nxt_serState.cmdWrite = serState_ff.shift[23];
            nxt_serState.cmdAddr = {serState_ff.shift[22:0], serState_ff.datLvl};
            if (serState_ff.shift[23]) begin
              nxt_serState.st = SP_WDATA;
            end else begin
              nxt_serState.cmdValid = 1'b1;
              nxt_serState.st = SP_RWAIT;
            end
          end
        end
      end
      SP_WDATA: begin
        if (clkRise) begin
          nxt_serState.shift = {serState_ff.shift[23:0], serState_ff.datLvl};
          nxt_serState.cnt = serState_ff.cnt + 5'h01;
          if (serState_ff.cnt == `SP_BYTE_BITS - 5'h01) begin
            nxt_serState.cnt = 5'h00;
            nxt_serState.cmdWdata = {serState_ff.shift[6:0], serState_ff.datLvl};
            nxt_serState.cmdValid = 1'b1;
            nxt_serState.st = SP_HEADER;
          end
        end
      end
      SP_RWAIT: begin
        if (cmd.rspValid) begin
          nxt_serState.shift = {17'h00000, cmd.rspData};
          nxt_serState.dataOut = cmd.rspData[7];
          nxt_serState.dataOe_n = 1'b0;
          nxt_serState.st = SP_RDATA;
        end
      end
      SP_RDATA: begin
        if (clkRise) begin
          nxt_serState.cnt = serState_ff.cnt + 5'h01;
          nxt_serState.shift = {serState_ff.shift[23:0], 1'b0};
          nxt_serState.dataOut = serState_ff.shift[6];
          if (serState_ff.cnt == `SP_BYTE_BITS - 5'h01) begin
            nxt_serState.cnt = 5'h00;
            nxt_serState.dataOe_n = 1'b1;
            nxt_serState.dataOut = 1'b0;
            nxt_serState.st = SP_HEADER;
          end
        end
      end
      default: begin
        nxt_serState.st = SP_HEADER;
        nxt_serState.dataOe_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serState_ff <= '0;
      serState_ff.st <= SP_HEADER;
      serState_ff.dataOe_n <= 1'b1;
    end else begin
      serState_ff <= nxt_serState;
    end
  end

  assign programDataPinOut  = serState_ff.dataOut;
  assign programDataPinOe_n = serState_ff.dataOe_n;
  assign cmd.cmdValid = serState_ff.cmdValid;
  assign cmd.cmdWrite = serState_ff.cmdWrite;
  assign cmd.cmdAddr  = serState_ff.cmdAddr;
  assign cmd.cmdWdata = serState_ff.cmdWdata;
endmodule : serial_prog_port

// File: logic/config_fuse_code_protection.sv
// Configuration word capture, option decode and program memory protection
`timescale 1ns/1ps
module config_fuse_code_protection
  import config_fuse_pkg::*;
#(
  parameter logic [23:0] BootEndAddr = `BOOT_END_DEFAULT
)
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        fetchValid,
  input  wire logic [23:0] fetchAddr,
  input  wire logic        flowValid,
  input  wire logic [23:0] flowSrcAddr,
  input  wire logic [23:0] flowDstAddr,
  input  wire logic        tblValid,
  input  wire logic        tblWrite,
  input  wire logic [23:0] tblAddr,
  input  wire logic [7:0]  tblWdata,
  input  wire logic [23:0] tblSrcAddr,
  input  wire logic [7:0]  memRdata,
  input  wire logic        programClockPin,
  input  wire logic        programDataPinIn,
  output logic             programDataPinOut,
  output logic             programDataPinOe_n,
  output logic             memReq,
  output logic             memWrite,
  output logic [23:0]      memAddr,
  output logic [7:0]       memWdata,
  output logic             tblAck,
  output logic             tblDeny,
  output logic [7:0]       tblRdata,
  output logic             fetchFault,
  output logic             illegalOpReset,
  output logic             cfgLoaded,
  output logic             bootSegmentEn,
  output logic             bootHighSecurity,
  output logic [1:0]       primaryOscModeSel,
  output logic             crystalMode,
  output logic             extClockMode,
  output logic             powerupTimerEn,
  output logic [1:0]       clockSwitchMonitorSel,
  output logic             clockOutPinSel,
  output logic             resetPinEn,
  output logic [1:0]       brownoutTripSel,
  output logic [1:0]       brownoutEnSel
);
  serial_cmd_if serCmd ();

  prot_state_t prot_ff;
  prot_state_t nxt_prot;

  logic [2:0] bootSec;
  logic       bootEn;
  logic       bootHigh;
  logic       tgtBoot;
  logic       srcBoot;
  logic       tgtCfg;
  logic [3:0] cfgHit;
  logic       tblRefuse;
  logic       spBoot;
  logic       spRefuse;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [23:0] cfgAddrOf(input logic [2:0] idx);
    case (idx)
      `IDX_BOOT:       return `OFS_BOOT_SEGMENT_PROTECT_CFG;
      `IDX_GENERAL:    return `OFS_GENERAL_SEGMENT_PROTECT_CFG;
      `IDX_OSC_SELECT: return `OFS_OSCILLATOR_SELECT_CFG;
      `IDX_OSC:        return `OFS_OSCILLATOR_CFG;
      `IDX_WATCHDOG:   return `OFS_WATCHDOG_CFG;
      `IDX_RESET:      return `OFS_RESET_CFG;
      default:         return `OFS_DEBUGGER_CFG;
    endcase
  endfunction : cfgAddrOf

  // Hit flag and word index of a configuration address
  function automatic logic [3:0] cfgLookup(input logic [23:0] a);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 7; i++) begin
      if (a == cfgAddrOf(3'(i))) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction : cfgLookup

  function automatic logic inBoot(input logic [23:0] a, input logic en);
    return en && (a >= `BOOT_ENTRY_LO) && (a <= BootEndAddr);
  endfunction : inBoot

  // ----------------------------------------------------------------------
  // Serial programming port
  // ----------------------------------------------------------------------
  serial_prog_port u_serial_prog_port (
    .clk                (clk),
    .rst_n              (rst_n),
    .programClockPin    (programClockPin),
    .programDataPinIn   (programDataPinIn),
    .programDataPinOut  (programDataPinOut),
    .programDataPinOe_n (programDataPinOe_n),
    .cmd                (serCmd.port)
  );

  // ----------------------------------------------------------------------
  // Capture, decode and access control
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_prot = prot_ff;
    nxt_prot.memReq = 1'b0;
    nxt_prot.memWrite = 1'b0;
    nxt_prot.tblAck = 1'b0;
    nxt_prot.tblDeny = 1'b0;
    nxt_prot.fetchFault = 1'b0;
    nxt_prot.illegalOpReset = 1'b0;
    nxt_prot.rspValid = 1'b0;
    nxt_prot.rdPend = prot_ff.memReq && !prot_ff.memWrite;
    nxt_prot.rdOwner = prot_ff.owner;

    bootSec = prot_ff.cfg[`IDX_BOOT][`BSS_HI:`BSS_LO];
    bootEn = (bootSec != `BSS_NONE);
    bootHigh = bootEn && (bootSec != `BSS_STD_A) && (bootSec != `BSS_STD_B);
    tgtBoot = inBoot(tblAddr, bootEn);
    srcBoot = inBoot(tblSrcAddr, bootEn);
    tgtCfg = (tblAddr >= `CFG_SPACE_BASE);
    cfgHit = cfgLookup(tblAddr);
    tblRefuse = (tgtBoot && !srcBoot) ||
                (tblWrite && !tgtCfg && tgtBoot &&
                 !prot_ff.cfg[`IDX_BOOT][`BOOT_WRITE_PROTECT_BIT]) ||
                (tblWrite && !tgtCfg && !tgtBoot &&
                 !prot_ff.cfg[`IDX_GENERAL][`GENERAL_WRITE_PROTECT_BIT]);
    spBoot = inBoot(prot_ff.spAddr, bootEn);
    spRefuse = spBoot ||
               (!spBoot && (prot_ff.spAddr < `CFG_SPACE_BASE) &&
                !prot_ff.cfg[`IDX_GENERAL][`GSS_BIT]);

    // Option decode from held words
    nxt_prot.cfgLoaded = (prot_ff.ld == LD_RUN);
    nxt_prot.bootSegmentEn = bootEn;
    nxt_prot.bootHighSecurity = bootHigh;
    nxt_prot.primaryOscModeSel = prot_ff.cfg[`IDX_OSC][`POSC_HI:`POSC_LO];
    nxt_prot.crystalMode =
      (prot_ff.cfg[`IDX_OSC][`POSC_HI:`POSC_LO] == `POSC_XT);
    nxt_prot.extClockMode =
      (prot_ff.cfg[`IDX_OSC][`POSC_HI:`POSC_LO] == `POSC_EC);
    nxt_prot.powerupTimerEn = prot_ff.cfg[`IDX_RESET][`POWERUP_TIMER_EN_BIT];
    nxt_prot.clockSwitchMonitorSel = prot_ff.cfg[`IDX_OSC][`CSM_HI:`CSM_LO];
    nxt_prot.clockOutPinSel = prot_ff.cfg[`IDX_OSC][`CLKOUT_BIT];
    nxt_prot.resetPinEn = prot_ff.cfg[`IDX_RESET][`RSTPIN_BIT];
    nxt_prot.brownoutTripSel = prot_ff.cfg[`IDX_RESET][`BROWNOUT_TRIP_SEL_HI:`BROWNOUT_TRIP_SEL_LO];
    nxt_prot.brownoutEnSel = prot_ff.cfg[`IDX_RESET][`BROWNOUT_EN_SEL_HI:`BROWNOUT_EN_SEL_LO];

    unique case (prot_ff.ld)
      LD_ISSUE: begin
        nxt_prot.memReq = 1'b1;
        nxt_prot.memAddr = cfgAddrOf(prot_ff.idx);
        nxt_prot.owner = OWN_LOAD;
        nxt_prot.ld = LD_WAIT;
      end
      LD_WAIT: begin
        if (prot_ff.rdPend && (prot_ff.rdOwner == OWN_LOAD)) begin
          nxt_prot.cfg[prot_ff.idx] = memRdata;
          if (prot_ff.idx == `CFG_LAST_IDX) begin
            nxt_prot.ld = LD_RUN;
          end else begin
            nxt_prot.idx = prot_ff.idx + 3'h1;
            nxt_prot.ld = LD_ISSUE;
          end
        end
      end
      LD_RUN: begin
        // Read data returning from the memory port
        if (prot_ff.rdPend && (prot_ff.rdOwner == OWN_TBL)) begin
          nxt_prot.tblAck = 1'b1;
          nxt_prot.tblRdata = memRdata;
        end
        if (prot_ff.rdPend && (prot_ff.rdOwner == OWN_SER)) begin
          nxt_prot.rspValid = 1'b1;
          nxt_prot.rspData = memRdata;
        end
        // Ordinary fetch at or above configuration space raises fetchFault
        nxt_prot.fetchFault = fetchValid && (fetchAddr >= `CFG_SPACE_BASE);
        // Boot entry window check on flow changes
        if (flowValid && bootHigh && !inBoot(flowSrcAddr, bootEn) &&
            inBoot(flowDstAddr, bootEn) && (flowDstAddr > `BOOT_ENTRY_HI)) begin
          nxt_prot.illegalOpReset = 1'b1;
        end
        // Table access has priority over the serial port
        if (tblValid) begin
          if (tgtCfg && cfgHit[3] && !tblWrite) begin
            nxt_prot.tblAck = 1'b1;
            nxt_prot.tblRdata = prot_ff.cfg[cfgHit[2:0]];
          end else if (!tgtCfg && tblRefuse) begin
            nxt_prot.tblAck = 1'b1;
            nxt_prot.tblDeny = 1'b1;
            nxt_prot.tblRdata = 8'h00;
          end else begin
            nxt_prot.memReq = 1'b1;
            nxt_prot.memWrite = tblWrite;
            nxt_prot.memAddr = tblAddr;
            nxt_prot.memWdata = tblWdata;
            nxt_prot.owner = OWN_TBL;
            nxt_prot.tblAck = tblWrite;
            nxt_prot.tblRdata = 8'h00;
          end
        end else if (prot_ff.spPend) begin
          nxt_prot.spPend = 1'b0;
          if (spRefuse) begin
            nxt_prot.rspValid = !prot_ff.spWrite;
            nxt_prot.rspData = `SP_REFUSED_DATA;
          end else begin
            nxt_prot.memReq = 1'b1;
            nxt_prot.memWrite = prot_ff.spWrite;
            nxt_prot.memAddr = prot_ff.spAddr;
            nxt_prot.memWdata = prot_ff.spWdata;
            nxt_prot.owner = OWN_SER;
          end
        end
      end
      default: begin
        nxt_prot.ld = LD_ISSUE;
      end
    endcase

    if (serCmd.cmdValid) begin
      nxt_prot.spPend = 1'b1;
      nxt_prot.spWrite = serCmd.cmdWrite;
      nxt_prot.spAddr = serCmd.cmdAddr;
      nxt_prot.spWdata = serCmd.cmdWdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prot_ff <= '0;
      prot_ff.ld <= LD_ISSUE;
      prot_ff.owner <= OWN_LOAD;
      prot_ff.rdOwner <= OWN_LOAD;
      prot_ff.cfg <= {`CFG_WORD_COUNT{`CFG_UNPROGRAMMED}};
    end else begin
      prot_ff <= nxt_prot;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign serCmd.rspValid = prot_ff.rspValid;
  assign serCmd.rspData = prot_ff.rspData;
  assign memReq = prot_ff.memReq;
  assign memWrite = prot_ff.memWrite;
  assign memAddr = prot_ff.memAddr;
  assign memWdata = prot_ff.memWdata;
  assign tblAck = prot_ff.tblAck;
  assign tblDeny = prot_ff.tblDeny;
  assign tblRdata = prot_ff.tblRdata;
  assign fetchFault = prot_ff.fetchFault;
  assign illegalOpReset = prot_ff.illegalOpReset;
  assign cfgLoaded = prot_ff.cfgLoaded;
  assign bootSegmentEn = prot_ff.bootSegmentEn;
  assign bootHighSecurity = prot_ff.bootHighSecurity;
  assign primaryOscModeSel = prot_ff.primaryOscModeSel;
  assign crystalMode = prot_ff.crystalMode;
  assign extClockMode = prot_ff.extClockMode;
  assign powerupTimerEn = prot_ff.powerupTimerEn;
  assign clockSwitchMonitorSel = prot_ff.clockSwitchMonitorSel;
  assign clockOutPinSel = prot_ff.clockOutPinSel;
  assign resetPinEn = prot_ff.resetPinEn;
  assign brownoutTripSel = prot_ff.brownoutTripSel;
  assign brownoutEnSel = prot_ff.brownoutEnSel;
endmodule : config_fuse_code_protection

// File: verification/config_fuse_code_protection_chk.sv
// Checker on the protection and decode ports
`timescale 1ns/1ps
module config_fuse_code_protection_chk #(parameter logic [23:0] BootEndAddr = 24'h0007ff) (
  input logic        clk, rst_n, fetchValid, flowValid, tblValid, tblAck, tblDeny, memReq,
  input logic        cfgLoaded, fetchFault, illegalOpReset, bootSegmentEn, bootHighSecurity,
  input logic        crystalMode, extClockMode, powerupTimerEn,
  input logic [23:0] fetchAddr, flowSrcAddr, flowDstAddr,
  input logic [7:0]  tblRdata,
  input logic [1:0]  primaryOscModeSel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic fromBoot;
  logic deepBoot;
  assign fromBoot = flowSrcAddr >= 24'h000200 && flowSrcAddr <= BootEndAddr;
  assign deepBoot = flowDstAddr > 24'h00023f && flowDstAddr <= BootEndAddr;
  a_fetch_fault: assert property (fetchFault == $past(fetchValid && fetchAddr[23]))
    else $error("fetch fault mismatch");
  a_bad_entry: assert property (
    flowValid && bootHighSecurity && !fromBoot && deepBoot |=> illegalOpReset)
    else $error("missing illegal entry reset");
  a_entry_ok: assert property (flowValid && flowDstAddr <= 24'h00023f |=> !illegalOpReset)
    else $error("reset on legal entry");
  a_flow_cause: assert property (!$past(flowValid) |-> !illegalOpReset)
    else $error("reset without flow change");
  a_deny_form: assert property (tblDeny |-> tblAck && tblRdata == 8'h00 && !memReq)
    else $error("refusal form wrong");
  a_tbl_answer: assert property (tblValid && cfgLoaded |-> ##[1:3] tblAck)
    else $error("table request unanswered");
  a_osc_decode: assert property (cfgLoaded |->
    crystalMode == (primaryOscModeSel == 2'h1) && extClockMode == (primaryOscModeSel == 2'h0))
    else $error("oscillator mode decode wrong");
  a_cfg_hold: assert property (cfgLoaded && $past(cfgLoaded) |->
    $stable({bootSegmentEn, bootHighSecurity, primaryOscModeSel, powerupTimerEn}))
    else $error("held configuration changed");
  a_high_boot: assert property (bootHighSecurity |-> bootSegmentEn)
    else $error("high security without boot segment");
endmodule : config_fuse_code_protection_chk

bind config_fuse_code_protection config_fuse_code_protection_chk
  #(.BootEndAddr(BootEndAddr)) config_fuse_code_protection_chk_i (.*);

// File: verification/flash_model.sv
// Flash model: fuse bytes at configuration words, address pattern elsewhere
`timescale 1ns/1ps
module flash_model #(parameter logic [55:0] Fuses = 56'hff_f7_ff_fd_ff_fe_f5) (
  input  logic        clk, memReq, memWrite,
  input  logic [23:0] memAddr,
  output logic [7:0]  memRdata
);
  logic [2:0] idx;
  initial memRdata = 8'h00;
  assign idx = memAddr[3:1] - {2'h0, memAddr[3:1] != 3'h0};
  // Idle bus toggles rather than holding the last byte
  always @(posedge clk)
    if (memReq && !memWrite && memAddr[23:4] == 20'hf8000 && memAddr[3:0] != 4'h2)
      memRdata <= Fuses[8*idx +: 8];
    else if (memReq && !memWrite) memRdata <= memAddr[7:0] ^ 8'h5a;
    else memRdata <= ~memRdata;
endmodule : flash_model

// File: verification/tb_config_fuse_code_protection.sv
// Self-checking bench for configuration capture and protection
`timescale 1ns/1ps
module tb_config_fuse_code_protection;
  localparam logic [55:0] Fuses = 56'hff_f7_ff_fd_ff_fe_f5;
  logic clk = 0, rst_n = 0, fetchValid = 0, flowValid = 0, tblValid = 0, tblWrite = 0, hit;
  logic programClockPin = 0, sdat = 0, programDataPinIn, programDataPinOut, programDataPinOe_n;
  logic memReq, memWrite, tblAck, tblDeny, fetchFault, illegalOpReset, cfgLoaded, bootSegmentEn;
  logic bootHighSecurity, crystalMode, extClockMode, powerupTimerEn;
  logic [23:0] fetchAddr = 0, flowSrcAddr = 0, flowDstAddr = 0, tblAddr = 0, tblSrcAddr = 0;
  logic [23:0] memAddr, a;
  logic [7:0]  tblWdata = 0, memRdata, tblRdata, got;
  logic [1:0]  primaryOscModeSel;
  logic [9:0]  q[$];
  logic [9:0]  e;
  int          errors = 0, checked = 0, cyc = 0;
  byte         offs[7] = '{0, 4, 6, 8, 10, 12, 14};

  assign programDataPinIn = programDataPinOe_n ? sdat : programDataPinOut;
  always #50 clk = ~clk;
  config_fuse_code_protection config_fuse_code_protection_i (.*, .memWdata(),
    .clockSwitchMonitorSel(), .clockOutPinSel(), .resetPinEn(), .brownoutTripSel(),
    .brownoutEnSel());
  flash_model #(.Fuses(Fuses)) flash_model_i (.clk, .memReq, .memWrite, .memAddr, .memRdata);

  task automatic chk(input string n, input logic [9:0] s, input logic [9:0] x);
    checked++;
    if (s !== x) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  task automatic end_of_test;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_of_test();
    end
  end

  always @(negedge clk) if (tblAck) begin
    e = q.pop_front();
    chk("table answer", {e[9], tblDeny, e[9] ? tblRdata : 8'h00}, e);
  end

  always @(posedge clk) if (cfgLoaded) begin
    fetchValid <= 1'b1;
    fetchAddr <= 24'($urandom);
  end

  task automatic tbl(input logic w, input logic [23:0] ad, s, input logic [9:0] x);
    @(posedge clk);
    tblValid <= 1'b1;
    tblWrite <= w;
    tblAddr <= ad;
    tblSrcAddr <= s;
    tblWdata <= ad[7:0];
    q.push_back(x);
    @(posedge clk);
    tblValid <= 1'b0;
    for (int i = 0; i < 8 && q.size() > 0; i++) @(posedge clk);
  endtask : tbl

  task automatic flow(input logic [23:0] s, d, input logic x);
    @(posedge clk);
    flowValid <= 1'b1;
    flowSrcAddr <= s;
    flowDstAddr <= d;
    @(posedge clk);
    flowValid <= 1'b0;
    hit = 0;
    repeat (3) @(negedge clk) hit |= illegalOpReset;
    @(posedge clk);
    chk("flow reset", {9'h0, hit}, {9'h0, x});
  endtask : flow

  task automatic sbit(input logic b);
    sdat <= b;
    repeat (6) @(posedge clk);
    programClockPin <= 1'b1;
    repeat (6) @(posedge clk);
    programClockPin <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : sbit

  task automatic sread(input logic [23:0] ad, input logic [7:0] x);
    for (int i = 24; i >= 0; i--) sbit(i == 24 ? 1'b0 : ad[i]);
    repeat (20) @(posedge clk);
    for (int i = 7; i >= 0; i--) begin
      got[i] = programDataPinIn;
      sbit(1'b0);
    end
    chk("serial read", {2'b00, got}, {2'b00, x});
  endtask : sread

  initial begin
    void'($urandom(4));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 60 && cfgLoaded !== 1'b1; i++) @(posedge clk);
    chk("decode", {3'b000, bootSegmentEn, bootHighSecurity, primaryOscModeSel, crystalMode,
      extClockMode, powerupTimerEn}, 10'b0001101100);
    $display("test decode done");
    foreach (offs[i]) tbl(1'b0, 24'hf80000 + 24'(offs[i]), 24'h001000, {2'b10, Fuses[8*i +: 8]});
    $display("test words done");
    tbl(1'b0, 24'h000300, 24'h001000, 10'h100);
    tbl(1'b1, 24'h000330, 24'h001000, 10'h100);
    tbl(1'b0, 24'h000310, 24'h000300, 10'h24a);
    tbl(1'b1, 24'h002000, 24'h000300, 10'h100);
    tbl(1'b1, 24'h000320, 24'h000300, 10'h000);
    repeat (4) begin
      a = 24'h000800 + 24'($urandom % 32'h7ff000);
      tbl(1'b0, a, 24'h001000, {2'b10, a[7:0] ^ 8'h5a});
    end
    $display("test table done");
    flow(24'h001000, 24'h00023f, 1'b0);
    flow(24'h001000, 24'h000240, 1'b1);
    flow(24'h000300, 24'h000400, 1'b0);
    $display("test flow done");
    sread(24'h000300, 8'h00);
    sread(24'h001000, 8'h5a);
    $display("test serial done");
    end_of_test();
  end
endmodule : tb_config_fuse_code_protection
